/* core/swgp_map.svh */
// register map, field positions, reset values and timing counts
`ifndef SWGP_MAP_SVH
`define SWGP_MAP_SVH
// ************************************************************
// register offsets
// ************************************************************
`define SWGP_OFS_GCTL   8'h0c
`define SWGP_OFS_FTEST  8'h0d
`define SWGP_OFS_PMC    8'h0e
`define SWGP_OFS_SLEEP  8'h0f
// ************************************************************
// field positions
// ************************************************************
`define SWGP_GCTL_RMII  6
`define SWGP_GCTL_CLKH  5
`define SWGP_GCTL_CLKL  4
`define SWGP_GCTL_PRE   2
`define SWGP_GCTL_TAIL  1
`define SWGP_GCTL_PFC   0
`define SWGP_PMC_PLL    5
`define SWGP_PMC_MODEH  4
`define SWGP_PMC_MODEL  3
// ************************************************************
// reset values and timing
// ************************************************************
`define SWGP_RST_CLKSEL 2'h1
`define SWGP_RST_PRE    1'h1
`define SWGP_RST_SLEEP  8'h50
`define SWGP_RST_FTEST  8'h00
`define SWGP_UNIT_MS    20
`define SWGP_CLK_MHZ    125
`define SWGP_UNIT_CYC   (`SWGP_UNIT_MS * 1000 * `SWGP_CLK_MHZ)
`define SWGP_SPD_SETTLE 4'h8
`endif

/* core/swgp_pkg.sv */
// types shared by the global power control block
package swgp_pkg;
  typedef enum logic [1:0] {
    SWGP_PM_NORMAL,
    SWGP_PM_ENERGY,
    SWGP_PM_SOFT_PD,
    SWGP_PM_SAVE
  } swgp_pm_e;
  typedef enum logic [1:0] {
    SWGP_CLK_41M,
    SWGP_CLK_83M,
    SWGP_CLK_125M,
    SWGP_CLK_RSVD
  } swgp_clk_e;
  typedef struct packed {
    logic        rmii_clk_mode;
    swgp_clk_e   clk_sel;
    logic        restore_pre;
    logic        tail_tag;
    logic        pass_fc;
    logic        pll_pd;
    swgp_pm_e    pm_mode;
    logic [7:0]  sleep_dly;
    logic        spd_arm;
    logic [3:0]  spd_cnt;
    logic        soft_pd;
    logic [7:0]  rdata;
    logic        rvalid;
  } swgp_main_s;
endpackage

/* core/swgp_regs.sv */
// global control and power management registers of the switch
`include "swgp_map.svh"

// Behaviour
// - port-5 reduced MAC clock mode is a read-only status caught from a strap.
// - two-bit field picks management clock; 01 after reset, 11 reserved.
// - restore-preamble bit, reset 1, makes port-five PHY regenerate 10 Mb/s preamble.
// - tail-tag bit set inserts one byte before FCS on port 5 only.
// - pass-flow-control bit set forwards flow-control packets; clear discards them.
// - PLL power-down bit 1 stops the PLL; reset 0 keeps it running.
// - mode field: 00 normal, 01 energy detect, 10 soft down, 11 saving.
// - power mode resets from strap: pull-up normal, pull-down energy detect.
// - sleep-delay register resets to 0x50, 80 units, 1.6 seconds.
module swgp_regs
  import swgp_pkg::*;
#(
  parameter int TICK_CYC = `SWGP_UNIT_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic              strap_rmii_clk_mode,
  input  wire logic              strap_pm_normal,
  input  wire logic              energy_det,
  output logic                   port5_rmii_clk_mode,
  output swgp_pkg::swgp_clk_e    mgmt_clk_sel,
  output logic                   port_five_phy_restore_pre,
  output logic                   port5_tail_tag_en,
  output logic                   pass_flow_ctrl,
  output logic                   pll_power_down,
  output swgp_pkg::swgp_pm_e     pm_mode,
  output logic                   soft_power_down,
  output logic                   low_power
);
  import swgp_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  swgp_main_s st_r;
  swgp_main_s st_nxt;
  logic [1:0] strap_q;
  logic       energy_q;
  logic       wr_gctl;
  logic       wr_pmc;
  logic       wr_sleep;
  logic       rd_pmc;
  logic [1:0] wr_clk;
  logic [1:0] wr_mode;
  logic       tmr_low;

  if (TICK_CYC < 2) begin : g_chk
    $error("swgp_regs: TICK_CYC must be at least 2");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  swgp_sync #(
    .W (2)
  ) u_strap_sync (
    .clk_sys (clk_sys),
    .d       ({strap_rmii_clk_mode, strap_pm_normal}),
    .q       (strap_q)
  );

  swgp_sync #(
    .W (1)
  ) u_energy_sync (
    .clk_sys (clk_sys),
    .d       (energy_det),
    .q       (energy_q)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  // write strobes for the control, power and sleep registers; read strobe for the power register only
  always_comb begin
    wr_gctl  = 1'b0;
    wr_pmc   = 1'b0;
    wr_sleep = 1'b0;
    rd_pmc   = 1'b0;
    if (reg_addr == `SWGP_OFS_GCTL) begin
      wr_gctl = reg_wr;
    end else if (reg_addr == `SWGP_OFS_PMC) begin
      wr_pmc = reg_wr;
      rd_pmc = reg_rd;
    end else if (reg_addr == `SWGP_OFS_SLEEP) begin
      wr_sleep = reg_wr;
    end
  end

  // written field values
  assign wr_clk  = reg_wdata[`SWGP_GCTL_CLKH:`SWGP_GCTL_CLKL];
  assign wr_mode = reg_wdata[`SWGP_PMC_MODEH:`SWGP_PMC_MODEL];

  // ************************************************************
  // register state
  // ************************************************************
  // next state of the control bits, soft power-down and read data
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = reg_rd;
    // control fields of the global control register
    if (wr_gctl) begin
      if (wr_clk != 2'(SWGP_CLK_RSVD)) begin
        st_nxt.clk_sel = swgp_clk_e'(wr_clk);
      end
      st_nxt.restore_pre = reg_wdata[`SWGP_GCTL_PRE];
      st_nxt.tail_tag    = reg_wdata[`SWGP_GCTL_TAIL];
      st_nxt.pass_fc     = reg_wdata[`SWGP_GCTL_PFC];
    end
    // soft power-down settles only while nobody reads the mode back
    if (st_r.spd_arm) begin
      if (rd_pmc) begin
        st_nxt.spd_arm = 1'b0;
      end else if (st_r.spd_cnt == `SWGP_SPD_SETTLE) begin
        st_nxt.spd_arm = 1'b0;
        st_nxt.soft_pd = 1'b1;
      end else begin
        st_nxt.spd_cnt = st_r.spd_cnt + 4'h1;
      end
    end
    // power management register write
    if (wr_pmc) begin
      st_nxt.pll_pd  = reg_wdata[`SWGP_PMC_PLL];
      st_nxt.pm_mode = swgp_pm_e'(wr_mode);
      st_nxt.spd_cnt = 4'h0;
      st_nxt.spd_arm = (wr_mode == 2'(SWGP_PM_SOFT_PD));
      if (wr_mode != 2'(SWGP_PM_SOFT_PD)) begin
        st_nxt.soft_pd = 1'b0;
      end
    end
    if (wr_sleep) begin
      st_nxt.sleep_dly = reg_wdata;
    end
    // read data; unmapped and reserved bits read zero
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `SWGP_OFS_GCTL) begin
        st_nxt.rdata[`SWGP_GCTL_RMII] = st_r.rmii_clk_mode;
        st_nxt.rdata[`SWGP_GCTL_CLKH:`SWGP_GCTL_CLKL] = st_r.clk_sel;
        st_nxt.rdata[`SWGP_GCTL_PRE]  = st_r.restore_pre;
        st_nxt.rdata[`SWGP_GCTL_TAIL] = st_r.tail_tag;
        st_nxt.rdata[`SWGP_GCTL_PFC]  = st_r.pass_fc;
      end else if (reg_addr == `SWGP_OFS_FTEST) begin
        st_nxt.rdata = `SWGP_RST_FTEST;
      end else if (reg_addr == `SWGP_OFS_PMC) begin
        st_nxt.rdata[`SWGP_PMC_PLL] = st_r.pll_pd;
        st_nxt.rdata[`SWGP_PMC_MODEH:`SWGP_PMC_MODEL] = st_r.pm_mode;
      end else if (reg_addr == `SWGP_OFS_SLEEP) begin
        st_nxt.rdata = st_r.sleep_dly;
      end
    end
  end

  // reset loads documented defaults and the strap levels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r               <= '0;
      st_r.rmii_clk_mode <= strap_q[1];
      st_r.clk_sel       <= swgp_clk_e'(`SWGP_RST_CLKSEL);
      st_r.restore_pre   <= `SWGP_RST_PRE;
      st_r.pm_mode       <= strap_q[0] ? SWGP_PM_NORMAL : SWGP_PM_ENERGY;
      st_r.sleep_dly     <= `SWGP_RST_SLEEP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // energy detect sleep timer
  // ************************************************************
  swgp_sleep_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_sleep (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .enable    (st_r.pm_mode == SWGP_PM_ENERGY),
    .energy    (energy_q),
    .delay     (st_r.sleep_dly),
    .low_power (tmr_low)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  // control outputs straight from the register state
  assign reg_rdata                 = st_r.rdata;
  assign reg_rvalid                = st_r.rvalid;
  assign port5_rmii_clk_mode       = st_r.rmii_clk_mode;
  assign mgmt_clk_sel              = st_r.clk_sel;
  assign port_five_phy_restore_pre = st_r.restore_pre;
  assign port5_tail_tag_en         = st_r.tail_tag;
  assign pass_flow_ctrl            = st_r.pass_fc;
  assign pll_power_down            = st_r.pll_pd;
  assign pm_mode                   = st_r.pm_mode;
  assign soft_power_down           = st_r.soft_pd;
  assign low_power                 = tmr_low;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_spd_write;
    reg_wr && reg_addr == `SWGP_OFS_PMC
      && reg_wdata[`SWGP_PMC_MODEH:`SWGP_PMC_MODEL] == 2'h2;
  endsequence

  sequence s_quiet_pmc;
    !(reg_rd && reg_addr == `SWGP_OFS_PMC) && !(reg_wr && reg_addr == `SWGP_OFS_PMC);
  endsequence

  sequence s_pmc_read;
    reg_rd && reg_addr == `SWGP_OFS_PMC;
  endsequence

  chk_rmii_status_fixed: assert property (
    reg_wr && reg_addr == `SWGP_OFS_GCTL |=> $stable(port5_rmii_clk_mode))
    else $error("clock mode status changed by a write");

  chk_clk_rsvd_kept: assert property (
    reg_wr && reg_addr == `SWGP_OFS_GCTL && reg_wdata[5:4] == 2'h3
      |=> mgmt_clk_sel == $past(mgmt_clk_sel) && mgmt_clk_sel != SWGP_CLK_RSVD)
    else $error("reserved clock code stored");

  chk_gctl_write: assert property (
    reg_wr && reg_addr == `SWGP_OFS_GCTL |=>
      port_five_phy_restore_pre == $past(reg_wdata[2])
      && port5_tail_tag_en == $past(reg_wdata[1])
      && pass_flow_ctrl == $past(reg_wdata[0]))
    else $error("control bits not taken from write");

  chk_pll_write: assert property (
    reg_wr && reg_addr == `SWGP_OFS_PMC |=> pll_power_down == $past(reg_wdata[5]))
    else $error("pll power-down not taken from write");

  chk_mode_write: assert property (
    reg_wr && reg_addr == `SWGP_OFS_PMC |=> pm_mode == swgp_pm_e'($past(reg_wdata[4:3])))
    else $error("power mode not taken from write");

  chk_spd_quiet: assert property (
    s_spd_write ##1 s_quiet_pmc [*8] ##1 s_quiet_pmc |=> soft_power_down)
    else $error("soft power-down not entered");

  chk_spd_readback: assert property (
    s_spd_write ##1 s_quiet_pmc ##1 s_pmc_read ##1 s_quiet_pmc [*8]
      |-> !soft_power_down)
    else $error("soft power-down taken despite read back");

  chk_reset_values: assert property (
    $fell(srst) |-> st_r.sleep_dly == 8'h50 && mgmt_clk_sel == SWGP_CLK_83M
      && port_five_phy_restore_pre && !port5_tail_tag_en && !pll_power_down)
    else $error("wrong reset values");

  chk_ftest_zero: assert property (
    reg_rd && reg_addr == `SWGP_OFS_FTEST |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("test register not zero");

  chk_pmc_read: assert property (
    reg_rd && reg_addr == `SWGP_OFS_PMC |=> reg_rdata[7:6] == 2'h0
      && reg_rdata[2:0] == 3'h0 && reg_rdata[4:3] == $past(pm_mode))
    else $error("power register read wrong");

  chk_low_only_energy: assert property (
    pm_mode != SWGP_PM_ENERGY |=> ##1 !low_power)
    else $error("low power outside energy mode");

  // strap levels caught in the last reset edge
  chk_strap_mode: assert property (
    $fell(srst) |-> pm_mode == ($past(strap_q[0]) ? SWGP_PM_NORMAL : SWGP_PM_ENERGY)
      && port5_rmii_clk_mode == $past(strap_q[1]))
    else $error("strap level not loaded in reset");

  chk_sleep_write: assert property (
    reg_wr && reg_addr == `SWGP_OFS_SLEEP |=> st_r.sleep_dly == $past(reg_wdata))
    else $error("sleep delay not taken from write");

  chk_spd_clear: assert property (
    reg_wr && reg_addr == `SWGP_OFS_PMC && reg_wdata[4:3] != 2'h2 |=> !soft_power_down)
    else $error("soft power-down kept after mode change");

  chk_unmapped_zero: assert property (
    reg_rd && (reg_addr < `SWGP_OFS_GCTL || reg_addr > `SWGP_OFS_SLEEP)
      |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  chk_idle_read_zero: assert property (
    !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read answer without a read");
endmodule

/* core/swgp_sleep_timer.sv */
// energy-detect sleep delay timer
`include "swgp_map.svh"
module swgp_sleep_timer #(
  parameter int TICK_CYC = `SWGP_UNIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       enable,
  input  wire logic       energy,
  input  wire logic [7:0] delay,
  output logic            low_power
);
  localparam int PW = (TICK_CYC < 2) ? 1 : $clog2(TICK_CYC);
  typedef struct packed {
    logic [PW-1:0] pre;
    logic [7:0]    units;
    logic          low;
  } swgp_tmr_s;
  swgp_tmr_s st_r;
  swgp_tmr_s st_nxt;

  if (TICK_CYC < 2) begin : g_chk
    $error("swgp_sleep_timer: TICK_CYC must be at least 2");
  end

  // count whole units of quiet line, restart on energy
  always_comb begin
    st_nxt = st_r;
    if (!enable || energy) begin
      st_nxt.pre   = '0;
      st_nxt.units = '0;
      st_nxt.low   = 1'b0;
    end else if (!st_r.low) begin
      if (st_r.units >= delay) begin
        st_nxt.low = 1'b1;
      end else if (st_r.pre == PW'(TICK_CYC - 1)) begin
        st_nxt.pre   = '0;
        st_nxt.units = st_r.units + 8'h01;
      end else begin
        st_nxt.pre = st_r.pre + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign low_power = st_r.low;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_energy_restart: assert property (
    enable && energy |=> !low_power && st_r.units == 8'h00 && st_r.pre == '0)
    else $error("timer not restarted by energy");
  chk_sleep_entry: assert property (
    $rose(low_power) |-> $past(st_r.units) >= $past(delay) && $past(enable))
    else $error("low power entered before the delay");
  chk_tick_step: assert property (
    enable && !energy && !low_power && st_r.pre == PW'(TICK_CYC - 1)
      && st_r.units < delay |=> st_r.units == $past(st_r.units) + 8'h01)
    else $error("unit count did not advance on tick");
endmodule

/* core/swgp_sync.sv */
// two flip-flop synchroniser for pin inputs
module swgp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } swgp_sync_s;
  swgp_sync_s st_r;
  swgp_sync_s st_nxt;

  if (W < 1) begin : g_chk
    $error("swgp_sync: width must be at least 1");
  end

  // first stage is read only by the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // data pipeline, no reset needed
  always_ff @(posedge clk_sys) begin
    st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule

/* tb/swgp_host.sv */
// host model driving the register strobe port of the global control block
module swgp_host (
  input  wire logic       clk_sys,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one-cycle write strobe; strobes follow the system clock, inside any
  // management clock limit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;  // released bus shows the inverse
    reg_wdata = ~d;
  endtask

  // one-cycle read strobe; data taken in the cycle after, unknown if absent
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

/* tb/tb_swgp_regs.sv */
// self-checking bench for the global control and power registers
`include "swgp_map.svh"
module tb_swgp_regs;
  import swgp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, srst, reg_wr, reg_rd, reg_rvalid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        strap_rmii_clk_mode, strap_pm_normal, energy_det;
  logic        rmii_mode, pre, tail, pfc, pll, soft_pd, low_power;
  swgp_clk_e   clk_sel;
  swgp_pm_e    pm_mode;
  int          n_fail, tests_run, i;

  // ************************************************************
  // clock, design and host
  // ************************************************************
  always #4 clk_sys = ~clk_sys;

  swgp_regs #(.TICK_CYC(4)) dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .strap_rmii_clk_mode(strap_rmii_clk_mode),
    .strap_pm_normal(strap_pm_normal), .energy_det(energy_det),
    .port5_rmii_clk_mode(rmii_mode), .mgmt_clk_sel(clk_sel),
    .port_five_phy_restore_pre(pre), .port5_tail_tag_en(tail),
    .pass_flow_ctrl(pfc), .pll_power_down(pll), .pm_mode(pm_mode),
    .soft_power_down(soft_pd), .low_power(low_power)
  );

  swgp_host host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  // ************************************************************
  // checking tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  // bounded wait for the sleep flag, run closed if it never arrives
  task automatic wait_lp(input logic v, input int lim);
    int n;
    n = 0;
    while (low_power !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({7'h00, low_power}, {7'h00, v});
    if (low_power !== v) end_of_test();
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    #1;
    srst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    srst = 1'b0;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    strap_rmii_clk_mode = 1'b1;
    strap_pm_normal = 1'b1;
    energy_det = 1'b1;
    n_fail = 0;
    tests_run = 0;
    do_reset();
    // reset values
    rd_chk(`SWGP_OFS_GCTL, 8'h54);
    rd_chk(`SWGP_OFS_FTEST, 8'h00);
    rd_chk(`SWGP_OFS_PMC, 8'h00);
    rd_chk(`SWGP_OFS_SLEEP, 8'h50);
    rd_chk(8'h10, 8'h00);
    chk({2'h0, tail, pfc, pll, soft_pd, 2'h0}, 8'h00);
    $display("test reset values done");
    // clock codes, refused code, control bits
    for (i = 0; i < 3; i++) begin
      host.wr(`SWGP_OFS_GCTL, {2'h0, i[1:0], 4'h0});
      chk({6'h00, clk_sel}, {6'h00, i[1:0]});
      rd_chk(`SWGP_OFS_GCTL, {2'h1, i[1:0], 4'h0});
    end
    host.wr(`SWGP_OFS_GCTL, 8'hff);
    rd_chk(`SWGP_OFS_GCTL, 8'h67);
    chk({5'h00, pre, tail, pfc}, 8'h07);
    host.wr(`SWGP_OFS_GCTL, 8'h00);
    chk({5'h00, pre, tail, pfc}, 8'h00);
    host.wr(`SWGP_OFS_FTEST, 8'hff);
    host.wr(8'h10, 8'hff);
    rd_chk(`SWGP_OFS_FTEST, 8'h00);
    rd_chk(`SWGP_OFS_GCTL, 8'h40);
    $display("test global control done");
    // power modes and PLL
    host.wr(`SWGP_OFS_PMC, 8'hff);
    rd_chk(`SWGP_OFS_PMC, 8'h38);
    chk({7'h00, pll}, 8'h01);
    for (i = 0; i < 4; i++) begin
      if (i != 2) begin
        host.wr(`SWGP_OFS_PMC, {3'h0, i[1:0], 3'h0});
        chk({6'h00, pm_mode}, {6'h00, i[1:0]});
        chk({7'h00, pll}, 8'h00);
      end
    end
    // soft power-down with and without a read back
    host.wr(`SWGP_OFS_PMC, 8'h10);
    repeat (12) @(posedge clk_sys);
    #1;
    chk({7'h00, soft_pd}, 8'h01);
    host.wr(`SWGP_OFS_PMC, 8'h00);
    chk({7'h00, soft_pd}, 8'h00);
    host.wr(`SWGP_OFS_PMC, 8'h10);
    rd_chk(`SWGP_OFS_PMC, 8'h10);
    repeat (12) @(posedge clk_sys);
    #1;
    chk({7'h00, soft_pd}, 8'h00);
    $display("test power modes done");
    // sleep timer with delay of two units
    host.wr(`SWGP_OFS_SLEEP, 8'h02);
    rd_chk(`SWGP_OFS_SLEEP, 8'h02);
    host.wr(`SWGP_OFS_PMC, 8'h08);
    repeat (4) @(posedge clk_sys);
    #1;
    chk({7'h00, low_power}, 8'h00);
    energy_det = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk({7'h00, low_power}, 8'h00);
    wait_lp(1'b1, 30);
    energy_det = 1'b1;
    wait_lp(1'b0, 6);
    energy_det = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    energy_det = 1'b1;
    @(posedge clk_sys);
    #1;
    energy_det = 1'b0;
    for (i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      #1;
      chk({7'h00, low_power}, 8'h00);
    end
    wait_lp(1'b1, 20);
    host.wr(`SWGP_OFS_PMC, 8'h00);
    wait_lp(1'b0, 4);
    $display("test sleep timer done");
    // straps pulled down
    strap_rmii_clk_mode = 1'b0;
    strap_pm_normal = 1'b0;
    do_reset();
    rd_chk(`SWGP_OFS_GCTL, 8'h14);
    rd_chk(`SWGP_OFS_PMC, 8'h08);
    chk({6'h00, pm_mode, rmii_mode}, 8'h02);
    host.wr(`SWGP_OFS_GCTL, 8'h54);
    rd_chk(`SWGP_OFS_GCTL, 8'h14);
    $display("test straps done");
    end_of_test();
  end
endmodule
